/* File: logic/agpc_pkg.sv */
// Package for the alarm flag and pin configuration block.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
// Function
// - Overtemp alarm pin latches low above threshold
// - Status holds latched and live temperature flags
// - Clear bit 6 write releases temperature latch
// - Guard clamp alarm disabled after reset
// - Control enables guard clamp alarm, picks latching
// - Guard clamp alarm only from enabled sources
// - Per-channel latched and live guard/clamp flags
// - Reset returns all state to power-on values
// - Strap selects serial or differential interface
// - Shared ground sense default, per-channel optional
// - Dual pin is guard input until reconfigured
package agpc_pkg;

  localparam int          AGPC_NCH          = 4;
  localparam logic [7:0]  AGPC_TEMP_DEFAULT = 8'h82; // 130 degrees C
  localparam int          AGPC_CLEAR_BIT    = 6;
  localparam logic        AGPC_GC_EN_RST    = 1'b0;
  localparam logic        AGPC_GC_LAT_RST   = 1'b0;
  localparam logic        AGPC_SRC_RST      = 1'b0;
  localparam logic [3:0]  AGPC_GSENSE_RST   = 4'h0;

  // Control bits written by software
  typedef struct packed {
    logic       gc_enable;   // Guard/clamp alarm pin enable
    logic       gc_latched;  // Latched pin behaviour
    logic       guard_src;   // Guard amplifier source enable
    logic       clamp_src;   // Clamp source enable
    logic [3:0] gsense_sep;  // Per-channel ground sense select
  } agpc_ctrl_s;

  // Alarm status word
  typedef struct packed {
    logic       temp_lat;
    logic       temp_live;
    logic [3:0] guard_lat;
    logic [3:0] guard_live;
    logic [3:0] clamp_lat;
    logic [3:0] clamp_live;
  } agpc_status_s;

  typedef enum logic [0:0] {
    AGPC_IF_SERIAL = 1'b0,
    AGPC_IF_DIFF   = 1'b1
  } agpc_if_e;

endpackage

/* File: logic/agpc_flag.sv */
`timescale 1ns/1ps
// Sticky flag with set-over-clear priority.
// Assumes synchronous inputs on the block clock.
module agpc_flag
  import agpc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Flag control
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_q
);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end

endmodule

/* File: logic/agpc_top.sv */
`timescale 1ns/1ps
// Alarm pin drive, alarm status flags and pin role configuration.
// Assumes analog comparators deliver live conditions synchronous to ref_clk.
module agpc_top
  import agpc_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Live conditions from analog side
  input  wire logic [7:0]   temp_now,
  input  wire logic [7:0]   temp_thresh,
  input  wire logic         temp_thresh_set,
  input  wire logic [3:0]   guard_fault,
  input  wire logic [3:0]   clamp_fault,
  // Software access
  input  wire logic         ctrl_wr,
  input  wire agpc_ctrl_s   ctrl_wdata,
  input  wire logic         chan_wr,
  input  wire logic [7:0]   chan_wdata,
  // Strap
  input  wire logic         if_select,
  // Alarm pins, open drain, oe low drives low
  output logic              overtemp_alarm_n_o,
  output logic              overtemp_alarm_n_oe,
  output logic              guard_clamp_alarm_n_o,
  output logic              guard_clamp_alarm_n_oe,
  // Status and configuration outputs
  output agpc_status_s      status_q,
  output agpc_ctrl_s        ctrl_q,
  output agpc_if_e          if_mode_q,
  output logic              compare_pins_diff_q,
  output logic [3:0]        target_ground_sense_sel_q,
  output logic [3:0]        guard_in_from_vh_q
);

  logic [7:0]   thresh_q;
  logic         temp_live_q;
  logic [3:0]   guard_live_q;
  logic [3:0]   clamp_live_q;
  logic         temp_lat;
  logic [3:0]   guard_lat;
  logic [3:0]   clamp_lat;
  logic         clear_req;
  logic         gc_live;
  logic         gc_lat;
  logic         gc_assert;

  // Clear bit in any channel write
  assign clear_req = chan_wr && chan_wdata[AGPC_CLEAR_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      thresh_q <= AGPC_TEMP_DEFAULT;
    end else if (temp_thresh_set) begin
      thresh_q <= temp_thresh;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      temp_live_q  <= 1'b0;
      guard_live_q <= 4'h0;
      clamp_live_q <= 4'h0;
    end else begin
      temp_live_q  <= (temp_now > thresh_q);
      guard_live_q <= guard_fault;
      clamp_live_q <= clamp_fault;
    end
  end

  agpc_flag u_temp_flag (
    .ref_clk (ref_clk),
    .rst     (rst),
    .set     (temp_live_q),
    .clr     (clear_req),
    .flag_q  (temp_lat)
  );

  for (genvar i = 0; i < AGPC_NCH; i++) begin : g_ch
    agpc_flag u_guard_flag (
      .ref_clk (ref_clk),
      .rst     (rst),
      .set     (guard_live_q[i]),
      .clr     (clear_req),
      .flag_q  (guard_lat[i])
    );
    agpc_flag u_clamp_flag (
      .ref_clk (ref_clk),
      .rst     (rst),
      .set     (clamp_live_q[i]),
      .clr     (clear_req),
      .flag_q  (clamp_lat[i])
    );
  end

  // Status word register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q.temp_lat   <= temp_lat;
      status_q.temp_live  <= temp_live_q;
      status_q.guard_lat  <= guard_lat;
      status_q.guard_live <= guard_live_q;
      status_q.clamp_lat  <= clamp_lat;
      status_q.clamp_live <= clamp_live_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q.gc_enable  <= AGPC_GC_EN_RST;
      ctrl_q.gc_latched <= AGPC_GC_LAT_RST;
      ctrl_q.guard_src  <= AGPC_SRC_RST;
      ctrl_q.clamp_src  <= AGPC_SRC_RST;
      ctrl_q.gsense_sep <= AGPC_GSENSE_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_wdata;
    end
  end

  // Alarm from enabled sources only
  function automatic logic src_hit(input agpc_ctrl_s cfg,
                                   input logic [3:0] grd,
                                   input logic [3:0] clp);
    src_hit = (cfg.guard_src && |grd) || (cfg.clamp_src && |clp);
  endfunction

  // Only enabled sources feed the pin
  assign gc_live = src_hit(ctrl_q, guard_live_q, clamp_live_q);
  assign gc_lat  = src_hit(ctrl_q, guard_lat, clamp_lat);
  assign gc_assert = ctrl_q.gc_enable &&
                     (ctrl_q.gc_latched ? gc_lat : gc_live);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      overtemp_alarm_n_o  <= 1'b0;
      overtemp_alarm_n_oe <= 1'b1;
    end else begin
      overtemp_alarm_n_o  <= 1'b0;
      overtemp_alarm_n_oe <= !temp_lat;
    end
  end

  // Guard clamp pin released unless enabled
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      guard_clamp_alarm_n_o  <= 1'b0;
      guard_clamp_alarm_n_oe <= 1'b1;
    end else begin
      guard_clamp_alarm_n_o  <= 1'b0;
      guard_clamp_alarm_n_oe <= !gc_assert;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      if_mode_q           <= AGPC_IF_SERIAL;
      compare_pins_diff_q <= 1'b0;
    end else begin
      if_mode_q           <= agpc_if_e'(if_select);
      compare_pins_diff_q <= if_select;
    end
  end

  // Ground sense and guard input routing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      target_ground_sense_sel_q <= AGPC_GSENSE_RST;
      guard_in_from_vh_q        <= AGPC_GSENSE_RST;
    end else begin
      target_ground_sense_sel_q <= ctrl_q.gsense_sep;
      guard_in_from_vh_q        <= ctrl_q.gsense_sep;
    end
  end

  // Assertions
  sequence temp_rise_s;
    temp_live_q && !rst;
  endsequence

  overtemp_drive_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    temp_rise_s |-> ##2 !overtemp_alarm_n_oe)
    else $error("overtemp pin not driven after alarm");

  temp_status_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> status_q.temp_live == $past(temp_live_q))
    else $error("live temperature flag wrong");

  temp_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    temp_lat && !clear_req |=> temp_lat)
    else $error("temperature latch dropped without clear");

  temp_clear_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clear_req && !temp_live_q |=> !temp_lat)
    else $error("temperature latch not cleared");

  gc_off_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !ctrl_q.gc_enable |=> guard_clamp_alarm_n_oe)
    else $error("guard clamp pin driven while disabled");

  gc_mode_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_q.gc_enable && !ctrl_q.gc_latched && gc_live
      |=> !guard_clamp_alarm_n_oe)
    else $error("unlatched guard clamp alarm missing");

  gc_source_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !ctrl_q.guard_src && !ctrl_q.clamp_src |=> guard_clamp_alarm_n_oe)
    else $error("guard clamp pin driven with no source");

  chan_flags_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    guard_live_q[1] |=> guard_lat[1] ##1 status_q.guard_lat[1])
    else $error("channel latched guard flag missing");

  reset_vals_a: assert property (
    @(posedge ref_clk)
    rst |=> !ctrl_q.gc_enable && status_q == '0 &&
      thresh_q == AGPC_TEMP_DEFAULT)
    else $error("state not at power-on value after reset");

  strap_sel_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> if_mode_q == agpc_if_e'($past(if_select)))
    else $error("interface mode does not follow strap");

  gsense_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> target_ground_sense_sel_q == $past(ctrl_q.gsense_sep))
    else $error("ground sense selection wrong");

  guard_route_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> guard_in_from_vh_q == $past(ctrl_q.gsense_sep))
    else $error("guard input routing mismatched");

  latch_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clamp_lat[2] && !clear_req |=> clamp_lat[2])
    else $error("latched clamp flag lost");

  temp_set_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    temp_live_q |=> temp_lat)
    else $error("temperature latch not set by live flag");

  ot_release_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !temp_lat |=> overtemp_alarm_n_oe)
    else $error("overtemp pin driven without latched alarm");

  thresh_load_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    temp_thresh_set |=> thresh_q == $past(temp_thresh))
    else $error("programmed threshold not loaded");

  temp_lat_copy_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> status_q.temp_lat == $past(temp_lat))
    else $error("latched temperature flag wrong");

  guard_clear_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clear_req && !(|guard_live_q) |=> !(|guard_lat))
    else $error("guard latches not cleared");

  gc_latch_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_q.gc_enable && ctrl_q.gc_latched && gc_lat
      |=> !guard_clamp_alarm_n_oe)
    else $error("latched guard clamp alarm missing");

  gc_release_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_q.gc_enable && !ctrl_q.gc_latched && !gc_live
      |=> guard_clamp_alarm_n_oe)
    else $error("unlatched guard clamp pin not released");

  sequence clamp_up_s;
    clamp_lat[2] ##1 status_q.clamp_lat[2];
  endsequence

  clamp_flags_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clamp_live_q[2] |=> clamp_up_s)
    else $error("channel latched clamp flag missing");

  clamp_live_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> status_q.clamp_live == $past(clamp_live_q))
    else $error("live clamp flags wrong");

  diff_pins_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> compare_pins_diff_q == $past(if_select))
    else $error("comparator pin role does not follow strap");

endmodule

/* File: dv/agpc_host.sv */
`timescale 1ns/1ps
// Host model: control, threshold and channel register writes.
// Assumes the bench calls wr; drives just after the ref_clk rise.
module agpc_host
  import agpc_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // Write strobes and data
  output logic       ctrl_wr,
  output agpc_ctrl_s ctrl_wdata,
  output logic       chan_wr,
  output logic [7:0] chan_wdata,
  output logic       temp_thresh_set,
  output logic [7:0] temp_thresh
);
  // Idle strobes at time zero
  initial begin
    {ctrl_wr, chan_wr, temp_thresh_set} = '0;
    {ctrl_wdata, chan_wdata, temp_thresh} = '0;
  end

  // Host register write
  // One-cycle strobe: k 0 ctrl, 1 threshold, 2 channel
  task automatic wr(input int k, input logic [7:0] d, input agpc_ctrl_s c);
    @(posedge ref_clk);
    #1;
    {chan_wdata, temp_thresh, ctrl_wdata} = {d, d, c};
    {chan_wr, temp_thresh_set, ctrl_wr} = 3'(1 << k);
    @(posedge ref_clk);
    #1;
    {chan_wr, temp_thresh_set, ctrl_wr} = '0;
    {chan_wdata, temp_thresh, ctrl_wdata} = ~{d, d, c}; // Stale data scrambled
  endtask
endmodule

/* File: dv/tb_agpc_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the alarm flag and pin configuration block.
// Assumes the host model for writes; bench drives analog conditions.
module tb_agpc_top
  import agpc_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         rst     = 1'b1;
  logic [7:0]   temp_now, temp_thresh, chan_wdata;
  logic [3:0]   guard_fault, clamp_fault, gsel, gvh;
  logic         if_select, ctrl_wr, chan_wr, temp_thresh_set;
  logic         ot_oe, gc_oe, diff_q, ot_o, gc_o;
  agpc_ctrl_s   ctrl_wdata, ctrl_q;
  agpc_status_s st;
  agpc_if_e     if_mode_q;
  int           n_fail = 0;
  int           checks = 0;

  // Clock and watchdog
  always #5 ref_clk = ~ref_clk;
  initial begin
    #100000;
    n_fail++;
    results();
  end

  agpc_host host (.ref_clk, .ctrl_wr, .ctrl_wdata, .chan_wr, .chan_wdata,
    .temp_thresh_set, .temp_thresh);

  agpc_top dut (.ref_clk, .rst, .temp_now, .temp_thresh, .temp_thresh_set,
    .guard_fault, .clamp_fault, .ctrl_wr, .ctrl_wdata, .chan_wr,
    .chan_wdata, .if_select, .overtemp_alarm_n_o(ot_o),
    .overtemp_alarm_n_oe(ot_oe), .guard_clamp_alarm_n_o(gc_o),
    .guard_clamp_alarm_n_oe(gc_oe), .status_q(st), .ctrl_q,
    .if_mode_q, .compare_pins_diff_q(diff_q),
    .target_ground_sense_sel_q(gsel), .guard_in_from_vh_q(gvh));

  // Wait n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Compare one value
  task automatic chk(input string nm, input logic [17:0] e,
                     input logic [17:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  // Power-on state of every output
  task automatic chk_rst();
    chk("ot_oe", 1, ot_oe);
    chk("ot_o", 0, ot_o);
    chk("gc_oe", 1, gc_oe);
    chk("gc_o", 0, gc_o);
    chk("status", 0, st);
    chk("ctrl", 0, ctrl_q);
    chk("if_mode", AGPC_IF_SERIAL, if_mode_q);
    chk("cmp_diff", 0, diff_q);
    chk("gnd_sel", 0, gsel);
    chk("guard_vh", 0, gvh);
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {temp_now, guard_fault, clamp_fault, if_select} = '0;
    cyc(10);
    rst = 1'b0;
    cyc(1);
    chk_rst();
    // Temperature threshold boundary, latch and clear
    temp_now = AGPC_TEMP_DEFAULT;
    cyc(4);
    chk("ot_oe", 1, ot_oe);
    temp_now = AGPC_TEMP_DEFAULT + 8'h01;
    cyc(4);
    chk("ot_oe", 0, ot_oe);
    chk("ot_o", 0, ot_o);
    chk("t_live", 1, st.temp_live);
    temp_now = 8'h10;
    host.wr(2, 8'hBF, '0);
    cyc(4);
    chk("t_lat", 1, st.temp_lat);
    chk("t_live", 0, st.temp_live);
    chk("ot_oe", 0, ot_oe);
    host.wr(2, 8'h40, '0);
    cyc(4);
    chk("ot_oe", 1, ot_oe);
    chk("t_lat", 0, st.temp_lat);
    // Programmed threshold; clear refused while live
    host.wr(1, 8'h0F, '0);
    cyc(4);
    chk("ot_oe", 0, ot_oe);
    host.wr(2, 8'h40, '0);
    cyc(4);
    chk("t_lat", 1, st.temp_lat);
    temp_now = 8'h00;
    host.wr(2, 8'h40, '0);
    // Guard/clamp pin disabled, then clamp only, unlatched
    clamp_fault = 4'h4;
    cyc(4);
    chk("t_lat", 0, st.temp_lat);
    chk("ot_oe", 1, ot_oe);
    chk("gc_oe", 1, gc_oe);
    host.wr(0, 8'h00, 8'h90);
    cyc(4);
    chk("gc_oe", 0, gc_oe);
    chk("gc_o", 0, gc_o);
    chk("c_live", 4'h4, st.clamp_live);
    clamp_fault = 4'h0;
    guard_fault = 4'h2;
    cyc(4);
    chk("gc_oe", 1, gc_oe);
    chk("g_live", 4'h2, st.guard_live);
    chk("c_lat", 4'h4, st.clamp_lat);
    // Both sources, latched pin
    host.wr(0, 8'h00, 8'hF0);
    cyc(4);
    chk("gc_oe", 0, gc_oe);
    guard_fault = 4'h0;
    cyc(4);
    chk("gc_oe", 0, gc_oe);
    chk("g_lat", 4'h2, st.guard_lat);
    chk("g_live", 4'h0, st.guard_live);
    host.wr(2, 8'h40, '0);
    cyc(4);
    chk("gc_oe", 1, gc_oe);
    chk("status", 0, st);
    // Strap and ground sense roles
    if_select = 1'b1;
    host.wr(0, 8'h00, 8'h0A);
    cyc(4);
    chk("if_mode", AGPC_IF_DIFF, if_mode_q);
    chk("cmp_diff", 1, diff_q);
    chk("gnd_sel", 4'hA, gsel);
    chk("guard_vh", 4'hA, gvh);
    // Mid-run reset with a latched alarm
    if_select = 1'b0;
    temp_now = 8'hFF;
    cyc(4);
    chk("ot_oe", 0, ot_oe);
    chk("if_mode", AGPC_IF_SERIAL, if_mode_q);
    chk("cmp_diff", 0, diff_q);
    temp_now = 8'h00;
    rst = 1'b1;
    cyc(10);
    chk_rst();
    rst = 1'b0;
    cyc(1);
    chk_rst();
    results();
  end
endmodule
